// File: src/c3cfg_regs.sv
// channel-3 input configuration and offset calibration registers, axi4-lite slave
`timescale 1ns/1ns

module c3cfg_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // axi4-lite write address and data
  input wire logic [c3cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [c3cfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // channel-3 controls toward the converter
  output logic [1:0] ch3_input_source_sel,
  output c3cfg_pkg::c3cfg_route_t ch3_route,
  output logic signed [23:0] ch3_offset_cal
);

  typedef enum {C3CFG_WR_IDLE, C3CFG_WR_RESP} c3cfg_wst_t;

  function automatic logic [7:0] word_idx(input logic [c3cfg_pkg::ADDR_W-1:0] a);
    word_idx = a[9:2];
  endfunction

  function automatic logic map_hit(input logic [c3cfg_pkg::ADDR_W-1:0] a);
    logic [7:0] i;
    i = word_idx(a);
    map_hit = (a[c3cfg_pkg::ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) &&
      (i == c3cfg_pkg::IDX_INPUT_CONFIG || i == c3cfg_pkg::IDX_OFFSET_HIGH ||
       i == c3cfg_pkg::IDX_OFFSET_LOW);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    merge = (v & m) | (old & ~m);
  endfunction

  // register state
  logic [15:0] cfg_r, cfg_nxt;
  logic [15:0] ofs_hi_r, ofs_hi_nxt;
  logic [15:0] ofs_lo_r, ofs_lo_nxt;

  // write channel state
  c3cfg_wst_t wst_r, wst_nxt;
  logic aw_held_r, aw_held_nxt;
  logic w_held_r, w_held_nxt;
  logic [c3cfg_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;

  // read channel state
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  logic do_write;
  logic [c3cfg_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign s_axi_awready = (wst_r == C3CFG_WR_IDLE) && !aw_held_r;
  assign s_axi_wready = (wst_r == C3CFG_WR_IDLE) && !w_held_r;
  assign s_axi_bvalid = (wst_r == C3CFG_WR_RESP);
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // write path: address and data captured in either order
  always_comb begin
    logic aw_have;
    logic w_have;
    logic [c3cfg_pkg::ADDR_W-1:0] a;
    logic [31:0] d;
    logic [3:0] s;
    aw_have = aw_held_r || (s_axi_awvalid && s_axi_awready);
    w_have = w_held_r || (s_axi_wvalid && s_axi_wready);
    a = aw_held_r ? awaddr_r : s_axi_awaddr;
    d = w_held_r ? wdata_r : s_axi_wdata;
    s = w_held_r ? wstrb_r : s_axi_wstrb;
    wst_nxt = wst_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    cfg_nxt = cfg_r;
    ofs_hi_nxt = ofs_hi_r;
    ofs_lo_nxt = ofs_lo_r;
    do_write = 1'b0;
    case (wst_r)
      C3CFG_WR_IDLE: begin
        if (aw_have && w_have) begin
          do_write = 1'b1;
          aw_held_nxt = 1'b0;
          w_held_nxt = 1'b0;
          wst_nxt = C3CFG_WR_RESP;
          bresp_nxt = map_hit(a) ? c3cfg_pkg::RESP_OKAY : c3cfg_pkg::RESP_SLVERR;
          if (map_hit(a)) begin
            case (word_idx(a))
              c3cfg_pkg::IDX_INPUT_CONFIG: begin
                cfg_nxt = merge(cfg_r, d, s, c3cfg_pkg::WMASK_INPUT_CONFIG);
              end
              c3cfg_pkg::IDX_OFFSET_HIGH: begin
                ofs_hi_nxt = merge(ofs_hi_r, d, s, c3cfg_pkg::WMASK_OFFSET_HIGH);
              end
              c3cfg_pkg::IDX_OFFSET_LOW: begin
                ofs_lo_nxt = merge(ofs_lo_r, d, s, c3cfg_pkg::WMASK_OFFSET_LOW);
              end
              default: begin
                cfg_nxt = cfg_r;
              end
            endcase
          end
        end else begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
          end
        end
      end
      C3CFG_WR_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = C3CFG_WR_IDLE;
        end
      end
      default: begin
        wst_nxt = C3CFG_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wst_r <= C3CFG_WR_IDLE;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= c3cfg_pkg::RESP_OKAY;
      cfg_r <= c3cfg_pkg::RST_INPUT_CONFIG;
      ofs_hi_r <= c3cfg_pkg::RST_OFFSET_HIGH;
      ofs_lo_r <= c3cfg_pkg::RST_OFFSET_LOW;
    end else begin
      wst_r <= wst_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
      cfg_r <= cfg_nxt;
      ofs_hi_r <= ofs_hi_nxt;
      ofs_lo_r <= ofs_lo_nxt;
    end
  end

  // read path: one cycle after address accepted
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = map_hit(s_axi_araddr) ? c3cfg_pkg::RESP_OKAY : c3cfg_pkg::RESP_SLVERR;
      rdata_nxt = 32'h0000_0000;
      if (map_hit(s_axi_araddr)) begin
        case (word_idx(s_axi_araddr))
          c3cfg_pkg::IDX_INPUT_CONFIG: rdata_nxt = {16'h0000, cfg_r};
          c3cfg_pkg::IDX_OFFSET_HIGH: rdata_nxt = {16'h0000, ofs_hi_r};
          c3cfg_pkg::IDX_OFFSET_LOW: rdata_nxt = {16'h0000, ofs_lo_r};
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= c3cfg_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // converter-facing controls
  assign ch3_input_source_sel = cfg_r[c3cfg_pkg::SEL_LSB +: c3cfg_pkg::SEL_W];
  always_comb begin
    ch3_route = '0;
    case (c3cfg_pkg::c3cfg_src_t'(ch3_input_source_sel))
      c3cfg_pkg::C3CFG_SRC_PAIR: ch3_route.pair_connect = 1'b1;
      c3cfg_pkg::C3CFG_SRC_SHORT: ch3_route.inputs_shorted = 1'b1;
      c3cfg_pkg::C3CFG_SRC_TEST_POS: ch3_route.test_pos = 1'b1;
      c3cfg_pkg::C3CFG_SRC_TEST_NEG: ch3_route.test_neg = 1'b1;
      default: ch3_route = '0;
    endcase
  end
  assign ch3_offset_cal = $signed({ofs_hi_r, ofs_lo_r[c3cfg_pkg::LOWBYTE_LSB +: 8]});

  // checks
  // write as the checks see it, held or live
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;

  sequence wr_taken_s;
    do_write;
  endsequence

  sequence resp_wait_s;
    s_axi_bvalid;
  endsequence

  sequence cfg_full_s;
    map_hit(wr_addr) && word_idx(wr_addr) == c3cfg_pkg::IDX_INPUT_CONFIG && wr_strb == 4'hf;
  endsequence

  sequence low_full_s;
    map_hit(wr_addr) && word_idx(wr_addr) == c3cfg_pkg::IDX_OFFSET_LOW && wr_strb == 4'hf;
  endsequence

  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  reset_value_a: assert property (@(posedge core_clk)
    $rose(rstn) |-> cfg_r == c3cfg_pkg::RST_INPUT_CONFIG)
    else $error("config not at reset value");
  reset_offset_a: assert property (@(posedge core_clk)
    $rose(rstn) |-> ch3_offset_cal == 24'sd0)
    else $error("offset not zero after reset");
  pair_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ch3_input_source_sel == 2'h0 |-> ch3_route == 4'h8)
    else $error("pair select wrong route");
  short_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ch3_input_source_sel == 2'h1 |-> ch3_route.inputs_shorted && !ch3_route.pair_connect)
    else $error("short select wrong route");
  test_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ch3_input_source_sel[1] |-> ch3_route.test_pos == !ch3_input_source_sel[0] &&
      ch3_route.test_neg == ch3_input_source_sel[0])
    else $error("test signal route wrong");
  high_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_taken_s ##0 (word_idx(aw_held_r ? awaddr_r : s_axi_awaddr) ==
      c3cfg_pkg::IDX_OFFSET_HIGH && (w_held_r ? wstrb_r : s_axi_wstrb) == 4'hf &&
      map_hit(aw_held_r ? awaddr_r : s_axi_awaddr))
      |=> ofs_hi_r == $past(w_held_r ? wdata_r[15:0] : s_axi_wdata[15:0]))
    else $error("offset high write lost");
  low_byte_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ofs_lo_r[7:0] == 8'h00 && ch3_offset_cal[7:0] == ofs_lo_r[15:8])
    else $error("offset low byte wrong");
  sign_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (ch3_offset_cal < 0) == ofs_hi_r[15])
    else $error("offset sign wrong");
  reserved_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cfg_r[5:3] == 3'h0)
    else $error("reserved config bits set");
  bresp_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_taken_s |=> resp_wait_s)
    else $error("write response missing");
  sel_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_taken_s ##0 cfg_full_s |=> ch3_input_source_sel == $past(wr_data[1:0]))
    else $error("select write lost");
  low_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_taken_s ##0 low_full_s |=> ofs_lo_r == {$past(wr_data[15:8]), 8'h00})
    else $error("offset low write wrong");
  bad_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_taken_s ##0 !map_hit(wr_addr) |=> $stable(cfg_r) && $stable(ofs_hi_r) &&
      $stable(ofs_lo_r) && s_axi_bresp == c3cfg_pkg::RESP_SLVERR)
    else $error("unmapped write took effect");
  read_answer_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_taken_s |=> s_axi_rvalid)
    else $error("read answer missing");

endmodule

// File: src/c3cfg_pkg.sv
// package for the channel-3 configuration and offset register slice
package c3cfg_pkg;

  // register indices (word address = index * 4)
  localparam logic [7:0] IDX_INPUT_CONFIG = 8'h18;
  localparam logic [7:0] IDX_OFFSET_HIGH = 8'h19;
  localparam logic [7:0] IDX_OFFSET_LOW = 8'h1a;
  localparam int ADDR_W = 12;

  // reset values
  localparam logic [15:0] RST_INPUT_CONFIG = 16'h0000;
  localparam logic [15:0] RST_OFFSET_HIGH = 16'h0000;
  localparam logic [15:0] RST_OFFSET_LOW = 16'h0000;

  // writable bits of each register
  localparam logic [15:0] WMASK_INPUT_CONFIG = 16'hffc7;
  localparam logic [15:0] WMASK_OFFSET_HIGH = 16'hffff;
  localparam logic [15:0] WMASK_OFFSET_LOW = 16'hff00;

  // field positions
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam int LOWBYTE_LSB = 8;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input source codes
  typedef enum logic [1:0] {
    C3CFG_SRC_PAIR = 2'h0,
    C3CFG_SRC_SHORT = 2'h1,
    C3CFG_SRC_TEST_POS = 2'h2,
    C3CFG_SRC_TEST_NEG = 2'h3
  } c3cfg_src_t;

  // analog front-end steering
  typedef struct packed {
    logic pair_connect;
    logic inputs_shorted;
    logic test_pos;
    logic test_neg;
  } c3cfg_route_t;

endpackage

// File: tb/tb_top.sv
// self-checking bench for the channel-3 configuration and offset register slice
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [c3cfg_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, r, sel;
  logic awready, wready, bvalid, arready, rvalid;
  c3cfg_pkg::c3cfg_route_t route;
  logic signed [23:0] ofs;
  logic [15:0] h, l;
  int miscompares = 0, checks = 0;

  always #5 core_clk = ~core_clk;

  c3cfg_regs u_c3cfg_regs (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ch3_input_source_sel(sel), .ch3_route(route),
    .ch3_offset_cal(ofs));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // aw and w offered together, each released at its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw_d, w_d, ar_s, wr_s, bv;
    int n;
    aw_d = 1'b0;
    w_d = 1'b0;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dt;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d) && n < 50) begin
      @(negedge core_clk);
      ar_s = awready;
      wr_s = wready;
      @(posedge core_clk);
      if (!aw_d && ar_s) begin
        awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (!w_d && wr_s) begin
        wvalid <= 1'b0;
        w_d = 1'b1;
      end
      n++;
    end
    bv = 1'b0;
    while (!bv && n < 100) begin
      @(negedge core_clk);
      bv = bvalid;
      resp = bresp;
      @(posedge core_clk);
      n++;
    end
    bready <= 1'b0;
    if (n >= 100) chk("write_timeout", 32'h1, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] resp);
    logic ok;
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok && n < 50) begin
      @(negedge core_clk);
      ok = arready;
      @(posedge core_clk);
      n++;
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok && n < 100) begin
      @(negedge core_clk);
      ok = rvalid;
      dt = rdata;
      resp = rresp;
      @(posedge core_clk);
      n++;
    end
    rready <= 1'b0;
    if (n >= 100) chk("read_timeout", 32'h1, 32'h0);
  endtask

  function automatic logic [31:0] exp_route(input logic [1:0] c);
    return {28'h0, 4'b1000 >> c};
  endfunction

  function automatic logic [31:0] exp_ofs(input logic [15:0] hi, input logic [15:0] lo);
    return {8'h0, hi, lo[15:8]};
  endfunction

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'he8c4));
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(12'h60 + 12'(4 * i), d, r);
      chk("reset_value", d, 32'h0);
      chk("reset_resp", {30'h0, r}, {30'h0, c3cfg_pkg::RESP_OKAY});
    end
    chk("reset_route", {28'h0, route}, exp_route(2'h0));
    chk("reset_offset", {8'h0, ofs}, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(12'h60, 32'h5a5a_0038 | 32'(c), 4'hf, r);
      chk("cfg_bresp", {30'h0, r}, {30'h0, c3cfg_pkg::RESP_OKAY});
      chk("cfg_sel", {30'h0, sel}, 32'(c));
      chk("cfg_route", {28'h0, route}, exp_route(2'(c)));
      rd(12'h60, d, r);
      chk("cfg_readback", d, 32'(c));
    end
    for (int k = 0; k < 10; k++) begin
      h = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7fff : 16'($urandom);
      l = (k == 0) ? 16'h00ff : (k == 1) ? 16'hffff : 16'($urandom);
      wr(12'h64, {16'($urandom), h}, 4'hf, r);
      wr(12'h68, {16'h0, l}, 4'hf, r);
      rd(12'h64, d, r);
      chk("ofs_high", d, {16'h0, h});
      rd(12'h68, d, r);
      chk("ofs_low", d, {16'h0, l & 16'hff00});
      chk("ofs_value", {8'h0, ofs}, exp_ofs(h, l));
      chk("ofs_sign", {31'h0, ofs < 0}, {31'h0, h[15]});
    end
    wr(12'h64, 32'h0000_1234, 4'b0010, r);
    rd(12'h64, d, r);
    chk("ofs_strobe", d, {16'h0, 8'h12, h[7:0]});
    for (int i = 0; i < 3; i++) begin
      wr((i == 0) ? 12'h6c : (i == 1) ? 12'h61 : 12'h5c, 32'h0, 4'hf, r);
      chk("bad_bresp", {30'h0, r}, {30'h0, c3cfg_pkg::RESP_SLVERR});
      rd((i == 0) ? 12'h6c : (i == 1) ? 12'h61 : 12'h5c, d, r);
      chk("bad_rdata", d, 32'h0);
      chk("bad_rresp", {30'h0, r}, {30'h0, c3cfg_pkg::RESP_SLVERR});
      chk("bad_no_effect", {30'h0, sel}, 32'h3);
    end
    // mid-run reset with non-zero contents
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(12'h60 + 12'(4 * i), d, r);
      chk("rerst_value", d, 32'h0);
    end
    chk("rerst_route", {28'h0, route}, exp_route(2'h0));
    chk("rerst_offset", {8'h0, ofs}, 32'h0);
    print_verdict();
  end
endmodule
